// *** verilog/dual_dac_map.svh ***
/*
 * constants for the dual converter serial load block: frame layout, register
 * select codes, reset values and the software register map.
 * assumes it is included by bare name from the package or the design.
 */
`ifndef DUAL_DAC_MAP_SVH
`define DUAL_DAC_MAP_SVH

// ----------------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------------
`define FRAME_BITS 24
`define FRAME_RW_BIT 23
`define FRAME_REG_HI 21
`define FRAME_REG_LO 19
`define FRAME_CH_HI 18
`define FRAME_CH_LO 16
`define DATA_BITS 16

// ----------------------------------------------------------------------------
// register select and channel codes
// ----------------------------------------------------------------------------
`define REG_FUNCTION 3'h0
`define REG_DATA 3'h2
`define REG_COARSE_GAIN 3'h3
`define REG_FINE_GAIN 3'h4
`define REG_OFFSET 3'h5
`define CH_A 3'h0
`define CH_B 3'h1
`define CH_BOTH 3'h4
`define FN_NOP 3'h0
`define FN_CONTROL 3'h1
`define FN_CLEAR 3'h4
`define FN_LOAD 3'h5

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define CTRL_OUT_DISABLE_BIT 0
`define CTRL_BITS 6
`define RESET_CODE 16'h0000
`define RESET_CTRL 6'h00
`define COARSE_BITS 2
`define FINE_BITS 6
`define OFFSET_BITS 8

// ----------------------------------------------------------------------------
// software register map (byte addresses)
// ----------------------------------------------------------------------------
`define ADDR_STATUS 4'h0
`define ADDR_OUT_A 4'h4
`define ADDR_OUT_B 4'h8
`define ADDR_CONTROL 4'hc

`endif

// *** verilog/dual_dac_pkg.sv ***
/*
 * types shared by the dual converter serial load block.
 * assumes the map header is on the include path.
 */
`include "dual_dac_map.svh"

package dual_dac_pkg;

	// ------------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------------
	typedef logic [`DATA_BITS-1:0] code_t;
	typedef logic [`FRAME_BITS-1:0] frame_t;
	typedef enum logic [1:0] {link_idle, link_shift, link_over} link_state_t;

endpackage : dual_dac_pkg

// *** verilog/dual_dac_serial_load_control.sv ***
/*
 * serial command front end and output update logic of a dual 16-bit
 * voltage-output converter, with an axi4-lite register view.
 * assumes: frame select, serial clock, data in, load strobe and clear are
 * asynchronous pins sampled by aclk (at least four aclk cycles per serial
 * clock phase); coding select is a static strap.
 */
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps

module dual_dac_serial_load_control
	import dual_dac_pkg::*;
#(
	parameter int CHANNELS = 2
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// serial link pins
	input wire logic frame_select_n,
	input wire logic serial_clk,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe,
	// update and coding pins
	input wire logic output_load_strobe_n,
	input wire logic clear_input_n,
	input wire logic coding_select,
	// converter core
	output dual_dac_pkg::code_t level_code_a,
	output dual_dac_pkg::code_t level_code_b,
	output logic [14:0] segment_a,
	output logic [11:0] ladder_a,
	output logic [14:0] segment_b,
	output logic [11:0] ladder_b,
	output logic [1:0] output_clamp,
	output logic [3:0] digital_io_ctrl,
	// axi4-lite slave
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import dual_dac_pkg::*;

	// ------------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------------
	// thermometer decode of the four top code bits
	function automatic logic [14:0] segments(input logic [3:0] top);
		logic [14:0] s;
		s = '0;
		for (int i = 0; i < 15; i++)
		begin
			s[i] = (32'(top) > i);
		end
		return s;
	endfunction : segments

	// channel hit for a channel field
	function automatic logic ch_hit(input logic [2:0] ch, input int idx);
		return (ch == `CH_BOTH) || (ch == 3'(idx));
	endfunction : ch_hit

	// ------------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------------
	logic [2:0] fs_s_r, sck_s_r, sdi_s_r, ld_s_r, clr_s_r;
	logic fs_q_r, sck_q_r, ld_q_r, clr_q_r;

	// three stages; a level counts once stages two and three agree
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fs_s_r <= 3'h7;
			sck_s_r <= 3'h7; // idle high, as the host parks it
			sdi_s_r <= 3'h0;
			ld_s_r <= 3'h7;
			clr_s_r <= 3'h7;
		end
		else
		begin
			fs_s_r <= {fs_s_r[1:0], frame_select_n};
			sck_s_r <= {sck_s_r[1:0], serial_clk};
			sdi_s_r <= {sdi_s_r[1:0], serial_in};
			ld_s_r <= {ld_s_r[1:0], output_load_strobe_n};
			clr_s_r <= {clr_s_r[1:0], clear_input_n};
		end
	end

	logic fs_nxt, sck_nxt, ld_nxt, clr_nxt;
	assign fs_nxt = (fs_s_r[2] == fs_s_r[1]) ? fs_s_r[2] : fs_q_r;
	assign sck_nxt = (sck_s_r[2] == sck_s_r[1]) ? sck_s_r[2] : sck_q_r;
	assign ld_nxt = (ld_s_r[2] == ld_s_r[1]) ? ld_s_r[2] : ld_q_r;
	assign clr_nxt = (clr_s_r[2] == clr_s_r[1]) ? clr_s_r[2] : clr_q_r;

	// filtered levels
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fs_q_r <= 1'b1;
			sck_q_r <= 1'b1;
			ld_q_r <= 1'b1;
			clr_q_r <= 1'b1;
		end
		else
		begin
			fs_q_r <= fs_nxt;
			sck_q_r <= sck_nxt;
			ld_q_r <= ld_nxt;
			clr_q_r <= clr_nxt;
		end
	end

	// edge events
	wire fs_fall = fs_q_r & ~fs_nxt;
	wire fs_rise = ~fs_q_r & fs_nxt;
	wire sck_fall = sck_q_r & ~sck_nxt & ~fs_q_r;
	wire sck_rise = ~sck_q_r & sck_nxt & ~fs_q_r;
	wire ld_fall = ld_q_r & ~ld_nxt;
	wire clr_fall = clr_q_r & ~clr_nxt;

	// ------------------------------------------------------------------------
	// frame shifter
	// ------------------------------------------------------------------------
	link_state_t state_r;
	frame_t shift_r;
	logic [4:0] count_r;
	logic sdo_r;
	logic ld_low_seen_r;

	// falling edges shift msb first; rising edges present the oldest bit
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r <= link_idle;
			shift_r <= '0;
			count_r <= '0;
			sdo_r <= 1'b0;
			ld_low_seen_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				link_idle:
				begin
					if (fs_fall)
					begin
						state_r <= link_shift;
						count_r <= '0;
						ld_low_seen_r <= 1'b1;
					end
				end
				link_shift, link_over:
				begin
					if (sck_fall)
					begin
						shift_r <= {shift_r[`FRAME_BITS-2:0], sdi_s_r[2]};
						if (count_r == 5'(`FRAME_BITS - 1))
						begin
							state_r <= link_over;
						end
						if (count_r != 5'h1f)
						begin
							count_r <= count_r + 5'h01;
						end
					end
					if (sck_rise)
					begin
						sdo_r <= shift_r[`FRAME_BITS-1];
					end
					if (ld_q_r)
					begin
						ld_low_seen_r <= 1'b0;
					end
					if (fs_rise)
					begin
						state_r <= link_idle;
					end
				end
				default:
				begin
					state_r <= link_idle;
				end
			endcase
		end
	end

	// frame decode at the end of a frame
	wire frame_ok = fs_rise && (count_r == 5'(`FRAME_BITS));
	wire rd_req = shift_r[`FRAME_RW_BIT];
	wire [2:0] reg_sel = shift_r[`FRAME_REG_HI:`FRAME_REG_LO];
	wire [2:0] ch_sel = shift_r[`FRAME_CH_HI:`FRAME_CH_LO];
	wire [`DATA_BITS-1:0] frame_data = shift_r[`DATA_BITS-1:0];
	wire wr_ok = frame_ok && !rd_req;
	wire wr_fn = wr_ok && (reg_sel == `REG_FUNCTION);
	wire sw_clear = wr_fn && (ch_sel == `FN_CLEAR);
	wire sw_load = wr_fn && (ch_sel == `FN_LOAD);

	// ------------------------------------------------------------------------
	// register file and outputs
	// ------------------------------------------------------------------------
	code_t data_r [CHANNELS];
	code_t out_r [CHANNELS];
	logic [`COARSE_BITS-1:0] coarse_r [CHANNELS];
	logic [`FINE_BITS-1:0] fine_r [CHANNELS];
	logic [`OFFSET_BITS-1:0] offset_r [CHANNELS];
	logic [`CTRL_BITS-1:0] ctrl_r;
	logic [CHANNELS-1:0] clamp_r;
	logic [CHANNELS-1:0] written_r;
	logic [23:0] read_word_r;

	wire sw_out_disable = ctrl_r[`CTRL_OUT_DISABLE_BIT];
	wire bulk_load = ld_fall | sw_load;
	wire [`DATA_BITS-1:0] clear_code = coding_select ? 16'h0000 : 16'h0000;

	// function register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_r <= `RESET_CTRL;
		end
		else if (wr_fn && ch_sel == `FN_CONTROL)
		begin
			ctrl_r <= frame_data[`CTRL_BITS-1:0];
		end
	end

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++)
		begin : g_ch
			wire hit = ch_hit(ch_sel, g);
			wire wr_data = wr_ok && hit && (reg_sel == `REG_DATA);
			// per channel storage and output update
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					data_r[g] <= `RESET_CODE;
					out_r[g] <= `RESET_CODE;
					clamp_r[g] <= 1'b1;
					written_r[g] <= 1'b0;
					coarse_r[g] <= '0;
					fine_r[g] <= '0;
					offset_r[g] <= '0;
				end
				else
				begin
					if (wr_data)
					begin
						data_r[g] <= frame_data;
						written_r[g] <= 1'b1;
					end
					if (wr_ok && hit && reg_sel == `REG_COARSE_GAIN)
					begin
						coarse_r[g] <= frame_data[`COARSE_BITS-1:0];
					end
					if (wr_ok && hit && reg_sel == `REG_FINE_GAIN)
					begin
						fine_r[g] <= frame_data[`FINE_BITS-1:0];
					end
					if (wr_ok && hit && reg_sel == `REG_OFFSET)
					begin
						offset_r[g] <= frame_data[`OFFSET_BITS-1:0];
					end
					if (clr_fall || sw_clear)
					begin
						out_r[g] <= clear_code;
						data_r[g] <= clear_code;
						clamp_r[g] <= 1'b0;
					end
					else if (wr_data && ld_low_seen_r && !ld_q_r)
					begin
						out_r[g] <= frame_data;
						clamp_r[g] <= 1'b0;
					end
					else if (bulk_load)
					begin
						out_r[g] <= data_r[g];
						clamp_r[g] <= 1'b0;
					end
				end
			end
			// offset binary view of the loaded code, then core switches
			wire [`DATA_BITS-1:0] ob = coding_select ? out_r[g] : {~out_r[g][15], out_r[g][14:0]};
			if (g == 0)
			begin : g_a
				assign level_code_a = ob;
				assign segment_a = segments(ob[15:12]);
				assign ladder_a = ob[11:0];
			end
			else if (g == 1)
			begin : g_b
				assign level_code_b = ob;
				assign segment_b = segments(ob[15:12]);
				assign ladder_b = ob[11:0];
			end
		end
	endgenerate

	assign output_clamp = clamp_r[1:0];
	assign digital_io_ctrl = ctrl_r[4:1];

	// word selected by a read frame, sent during the following frame
	wire ch_b = (ch_sel == `CH_B);
	wire [`DATA_BITS-1:0] rd_value =
		(reg_sel == `REG_DATA) ? data_r[ch_b] :
		(reg_sel == `REG_COARSE_GAIN) ? {14'h0000, coarse_r[ch_b]} :
		(reg_sel == `REG_FINE_GAIN) ? {10'h000, fine_r[ch_b]} :
		(reg_sel == `REG_OFFSET) ? {8'h00, offset_r[ch_b]} :
		{10'h000, ctrl_r};

	// readback latch loads the shifter's view only between frames
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			read_word_r <= '0;
		end
		else if (frame_ok && rd_req)
		begin
			read_word_r <= {shift_r[23:16], rd_value};
		end
		else if (frame_ok)
		begin
			read_word_r <= '0;
		end
	end

	// a pending read drives serial out from the readback latch for the first 24 bits of the next frame, in place of the shifter
	logic rd_pending_r;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_pending_r <= 1'b0;
		end
		else if (frame_ok)
		begin
			rd_pending_r <= rd_req;
		end
	end

	wire sdo_value = (rd_pending_r && state_r != link_idle && count_r < 5'(`FRAME_BITS))
		? read_word_r[5'(`FRAME_BITS - 1) - count_r] : sdo_r;
	assign serial_out = sw_out_disable ? 1'b0 : sdo_value;
	assign serial_out_oe = ~sw_out_disable;

	// ------------------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------------------
	logic aw_held_r, w_held_r;
	logic [3:0] aw_addr_r;
	logic bvalid_r, rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] bresp_r, rresp_r;

	assign s_axi_awready = ~aw_held_r & ~bvalid_r;
	assign s_axi_wready = ~w_held_r & ~bvalid_r;
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	wire aw_now = aw_held_r | (s_axi_awvalid & s_axi_awready);
	wire w_now = w_held_r | (s_axi_wvalid & s_axi_wready);
	wire [3:0] aw_eff = aw_held_r ? aw_addr_r : s_axi_awaddr;
	wire [31:0] rd_mux =
		(s_axi_araddr == `ADDR_STATUS) ? {26'h0000000, rd_pending_r, clamp_r[1:0], state_r != link_idle,
			written_r[1:0]} :
		(s_axi_araddr == `ADDR_OUT_A) ? {16'h0000, out_r[0]} :
		(s_axi_araddr == `ADDR_OUT_B) ? {16'h0000, out_r[1]} :
		(s_axi_araddr == `ADDR_CONTROL) ? {26'h0000000, ctrl_r} : 32'h00000000;
	wire rd_known = (s_axi_araddr == `ADDR_STATUS) || (s_axi_araddr == `ADDR_OUT_A) ||
		(s_axi_araddr == `ADDR_OUT_B) || (s_axi_araddr == `ADDR_CONTROL);

	// write side: address and data in either order, one response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= '0;
			bvalid_r <= 1'b0;
			bresp_r <= 2'h0;
		end
		else if (aw_now && w_now && !bvalid_r)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			bvalid_r <= 1'b1;
			bresp_r <= (aw_eff == `ADDR_STATUS || aw_eff == `ADDR_OUT_A || aw_eff == `ADDR_OUT_B) ? 2'h0 : 2'h2;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_r <= 1'b1;
			end
			if (bvalid_r && s_axi_bready)
			begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// read side: one cycle answer
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= 2'h0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_mux;
			rresp_r <= rd_known ? 2'h0 : 2'h2;
		end
		else if (rvalid_r && s_axi_rready)
		begin
			rvalid_r <= 1'b0;
		end
	end

endmodule : dual_dac_serial_load_control

// *** verification/dual_dac_checker.sv ***
/*
 concurrent checks on the pins of the dual converter load block.
 assumes one aclk domain and a synchronous active low reset.
*/
`timescale 1ns/10ps

module dual_dac_checker
	import dual_dac_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pins
	input wire logic frame_select_n,
	input wire logic output_load_strobe_n,
	input wire logic clear_input_n,
	input wire logic coding_select,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	// converter core
	input wire dual_dac_pkg::code_t level_code_a,
	input wire dual_dac_pkg::code_t level_code_b,
	input wire logic [14:0] segment_a,
	input wire logic [11:0] ladder_a,
	input wire logic [1:0] output_clamp,
	input wire logic [3:0] digital_io_ctrl
);
	// ----------------
	// assertions
	// ----------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// zero code as seen at the level outputs for the strap setting
	logic [15:0] zero_view;
	assign zero_view = coding_select ? 16'h0000 : 16'h8000;

	chk_reset_clamp: assert property ($rose(aresetn) |-> output_clamp == 2'h3 && level_code_a == zero_view)
		else $error("outputs not clamped at zero code after reset");
	chk_strobe_update: assert property ($fell(output_load_strobe_n) |-> ##[1:8] output_clamp == 2'h0)
		else $error("strobe fall did not release the outputs");
	chk_clear_level: assert property ($fell(clear_input_n) |-> ##[1:8] level_code_b == zero_view)
		else $error("clear edge did not force the clear level");
	chk_out_hold: assert property ((frame_select_n && output_load_strobe_n && clear_input_n) [*8]
		|-> $stable(level_code_a) || $changed(coding_select))
		else $error("output changed without an update");
	chk_idle_ignore: assert property (frame_select_n [*8] |-> $stable(digital_io_ctrl))
		else $error("control bits changed outside a frame");
	chk_seg_map: assert property (segment_a == (15'h7fff >> (4'hf - level_code_a[15:12])))
		else $error("segment controls do not match the top code bits");
	chk_ladder_map: assert property (ladder_a == level_code_a[11:0])
		else $error("ladder switches do not match the low code bits");
	chk_out_quiet: assert property (!serial_out_oe |-> serial_out == 1'b0)
		else $error("serial out active while disabled");

	// main scenarios
	cover property ($fell(output_load_strobe_n));
	cover property ($fell(clear_input_n));
	cover property ($fell(serial_out_oe));
endmodule : dual_dac_checker

// *** verification/host_serial_model.sv ***
/*
 host serial port model: frames of up to 48 bits, msb first, clock parked
 high between frames, capture of serial out just before each falling edge.
 assumes one serial clock phase is 16 aclk edges (160 ns period at 200 MHz).
*/
`timescale 1ns/10ps

module host_serial_model
(
	// clock
	input wire logic aclk,
	// serial link pins
	output logic frame_select_n,
	output logic serial_clk,
	output logic serial_in,
	input wire logic serial_out
);
	// ----------------
	// frame driver
	// ----------------
	initial
	begin
		frame_select_n = 1'b1;
		serial_clk = 1'b1;
		serial_in = 1'b0;
	end

	// wait n aclk edges
	task automatic hold(input int n);
		repeat (n) @(posedge aclk);
	endtask : hold

	// n bits of w, msb first; cap gets serial out seen before each fall
	task automatic send(input int n, input logic [47:0] w, output logic [47:0] cap);
		cap = '0;
		frame_select_n <= 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			serial_in <= w[i];
			hold(16);
			cap[i] = serial_out;
			serial_clk <= 1'b0;
			hold(16);
			serial_clk <= 1'b1;
		end
		hold(16);
		frame_select_n <= 1'b1;
		serial_in <= ~w[0];
		hold(16);
	endtask : send
endmodule : host_serial_model

// *** verification/dual_dac_serial_load_control_test.sv ***
/*
 self-checking bench: serial frames through the host model, update pins,
 coding strap and axi4-lite accesses.
 assumes the checker and the host model are compiled before this file.
*/
`timescale 1ns/10ps

module dual_dac_serial_load_control_test
	import dual_dac_pkg::*;
;
	// ----------------
	// signals
	// ----------------
	logic aclk = 1'b0;
	logic aresetn, frame_select_n, serial_clk, serial_in, serial_out, serial_out_oe;
	logic output_load_strobe_n, clear_input_n, coding_select;
	code_t level_code_a, level_code_b;
	logic [14:0] segment_a, segment_b;
	logic [11:0] ladder_a, ladder_b;
	logic [1:0] output_clamp, s_axi_bresp, s_axi_rresp, rr;
	logic [3:0] digital_io_ctrl, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [47:0] cap;
	int errors = 0;
	int checks_done = 0;

	always #2.5 aclk = ~aclk;

	dual_dac_serial_load_control i_dut (.*);
	host_serial_model i_host (.*);

	// ----------------
	// helpers
	// ----------------
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out

	// level outputs are the offset binary view of the loaded codes
	task automatic outs(input code_t a, input code_t b);
		cmp(level_code_a, coding_select ? a : {~a[15], a[14:0]});
		cmp(level_code_b, coding_select ? b : {~b[15], b[14:0]});
	endtask : outs

	task automatic fr(input frame_t w);
		i_host.send(24, {24'h0, w}, cap);
	endtask : fr

	task automatic load_pulse;
		output_load_strobe_n <= 1'b0;
		repeat (8) @(posedge aclk);
		output_load_strobe_n <= 1'b1;
		repeat (12) @(posedge aclk);
	endtask : load_pulse

	// write all ones, expect response er
	task automatic axi_wr(input logic [3:0] a, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		cmp(s_axi_bresp, er);
		@(posedge aclk);
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : axi_rd

	// ----------------
	// tests
	// ----------------
	initial
	begin
		aresetn = 1'b0;
		output_load_strobe_n = 1'b1;
		clear_input_n = 1'b1;
		coding_select = 1'b1;
		s_axi_awaddr = 4'h0;
		s_axi_wdata = 32'hffff_ffff;
		s_axi_wstrb = 4'hf;
		s_axi_araddr = 4'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		// reset state and status view
		cmp(output_clamp, 2'h3);
		outs(16'h0000, 16'h0000);
		cmp(serial_out_oe, 1'b1);
		axi_rd(4'h0);
		cmp(rd[4:3], 2'h3);
		cmp(rr, 2'h0);
		// strobe alone releases the zero code
		load_pulse;
		cmp(output_clamp, 2'h0);
		// individual update, then simultaneous update of channel b
		output_load_strobe_n <= 1'b0;
		fr(24'h10_1234);
		output_load_strobe_n <= 1'b1;
		outs(16'h1234, 16'h0000);
		fr(24'h11_abcd);
		outs(16'h1234, 16'h0000);
		load_pulse;
		outs(16'h1234, 16'habcd);
		cmp(segment_a, 15'h0001);
		cmp(ladder_a, 12'h234);
		cmp(segment_b, 15'h03ff);
		cmp(ladder_b, 12'hbcd);
		// short and long frames are dropped
		output_load_strobe_n <= 1'b0;
		i_host.send(23, 48'h10_0f0f, cap);
		i_host.send(25, 48'h20_0f0f, cap);
		output_load_strobe_n <= 1'b1;
		outs(16'h1234, 16'habcd);
		// both channels, software clear, software load
		fr(24'h14_5555);
		load_pulse;
		outs(16'h5555, 16'h5555);
		fr(24'h04_0000);
		outs(16'h0000, 16'h0000);
		fr(24'h10_4321);
		fr(24'h05_0000);
		outs(16'h4321, 16'h0000);
		// register view: output codes, unmapped read, ignored and refused writes
		axi_rd(4'h4);
		cmp(rd[15:0], 16'h4321);
		cmp(rr, 2'h0);
		axi_rd(4'h8);
		cmp(rd, 32'h0000_0000);
		axi_rd(4'h2);
		cmp(rd, 32'h0000_0000);
		cmp(rr, 2'h2);
		axi_wr(4'h4, 2'h0);
		axi_wr(4'hc, 2'h2);
		outs(16'h4321, 16'h0000);
		// clear pin edge
		clear_input_n <= 1'b0;
		repeat (8) @(posedge aclk);
		clear_input_n <= 1'b1;
		repeat (12) @(posedge aclk);
		outs(16'h0000, 16'h0000);
		// gain and offset readback chained through read frames
		fr(24'h20_002a);
		fr(24'h29_0055);
		fr(24'h18_0003);
		fr(24'ha0_ffff);
		axi_rd(4'h0);
		cmp(rd[5], 1'b1);
		fr(24'ha9_0000);
		cmp(cap[23:16], 8'ha0);
		cmp(cap[15:0], 16'h002a);
		fr(24'h98_0000);
		cmp(cap[23:0], 24'ha9_0055);
		fr(24'ha0_0000);
		cmp(cap[23:0], 24'h98_0003);
		fr(24'h00_0000);
		cmp(cap[15:0], 16'h002a);
		// excess bits leave on serial out
		i_host.send(48, {24'h10_7777, 24'h11_1111}, cap);
		cmp(cap[23:0], 24'h10_7777);
		// control: serial out disabled, io bits, then enabled again
		fr(24'h01_001f);
		cmp(serial_out_oe, 1'b0);
		cmp(digital_io_ctrl, 4'hf);
		axi_rd(4'hc);
		cmp(rd[5:0], 6'h1f);
		fr(24'h01_0000);
		cmp(serial_out_oe, 1'b1);
		// twos complement strap: zero code sits mid-scale
		coding_select <= 1'b0;
		repeat (2) @(posedge aclk);
		outs(16'h0000, 16'h0000);
		cmp(segment_a, 15'h00ff);
		cmp(segment_b, 15'h00ff);
		cmp(ladder_b, 12'h000);
		close_out;
	end

	// watchdog
	initial
	begin
		#200000;
		errors++;
		close_out;
	end
endmodule : dual_dac_serial_load_control_test

bind dual_dac_serial_load_control dual_dac_checker i_chk (
	.aclk(aclk),
	.aresetn(aresetn),
	.frame_select_n(frame_select_n),
	.output_load_strobe_n(output_load_strobe_n),
	.clear_input_n(clear_input_n),
	.coding_select(coding_select),
	.serial_out(serial_out),
	.serial_out_oe(serial_out_oe),
	.level_code_a(level_code_a),
	.level_code_b(level_code_b),
	.segment_a(segment_a),
	.ladder_a(ladder_a),
	.output_clamp(output_clamp),
	.digital_io_ctrl(digital_io_ctrl)
);
